// *** hw/usf_top.sv ***
// Serial port status flags, interrupt enables and data buffers behind an APB slave
//
// Behaviour
// RULE1: Transmit request when enabled and holding empty.
// RULE2: Receive request on load or any error.
// RULE3: Order bit picks LSB or MSB first.
// RULE4: Order change after write voids pending byte.
// RULE5: Buffer write clears holding-empty flag.
// RULE6: Shift load sets holding-empty flag.
// RULE7: Received character load sets buffer-full flag.
// RULE8: Reading receive buffer clears buffer-full flag.
// RULE9: Framing error sets framing flag.
// RULE10: New character while unread sets overrun.
// RULE11: Parity mismatch sets parity flag.
// RULE12: Error flags clear only by zero write.
// RULE13: Receive buffer invalid while any error.
// RULE14: Seven-bit mode drops buffer top bit.
// RULE15: One address: read receive, write transmit.
// RULE16: Requests stay while enable and source.
module usf_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usf_pkg::USF_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit shift engine
    input wire logic tx_shift_load,
    output logic tx_byte_valid,
    output logic [7:0] tx_shift_byte,
    // Receive engine
    input wire logic rx_load,
    input wire logic [7:0] rx_char,
    input wire logic rx_framing_err,
    input wire logic rx_parity_err,
    output logic rx_data_valid,
    // Mode and interrupt outputs
    output logic bit_order_select,
    output logic seven_bit_mode,
    output logic tx_irq_req,
    output logic rx_irq_req,
    output logic irq
);
    import usf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    function automatic logic usf_hit(input logic [USF_AW-1:0] a, input logic [USF_AW-1:0] r);
        return a == r;
    endfunction : usf_hit

    logic acc;
    logic wr;
    logic rd;
    logic mapped;

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    always_comb begin
        if (usf_hit(paddr, USF_STAT_ADDR)) begin
            mapped = 1'b1;
        end else if (usf_hit(paddr, USF_DATA_ADDR)) begin
            mapped = 1'b1;
        end else if (usf_hit(paddr, USF_CTRL_ADDR)) begin
            mapped = 1'b1;
        end else if (usf_hit(paddr, USF_ISTAT_ADDR)) begin
            mapped = 1'b1;
        end else if (usf_hit(paddr, USF_IMASK_ADDR)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Unmapped access: error response, and any write is dropped
    assign pslverr = acc & ~mapped;

    logic wr_stat;
    logic wr_data;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    logic rd_data;

    assign wr_stat = wr & usf_hit(paddr, USF_STAT_ADDR);
    // RULE15 shared address
    assign wr_data = wr & usf_hit(paddr, USF_DATA_ADDR);
    assign rd_data = rd & usf_hit(paddr, USF_DATA_ADDR);
    assign wr_ctrl = wr & usf_hit(paddr, USF_CTRL_ADDR);
    assign wr_istat = wr & usf_hit(paddr, USF_ISTAT_ADDR);
    assign wr_imask = wr & usf_hit(paddr, USF_IMASK_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // Software controlled bits

    logic tx_irq_en_reg;
    logic rx_irq_en_reg;
    logic order_reg;
    logic seven_reg;
    logic order_change;

    // A status write replaces all three software bits; the flags are read-only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_irq_en_reg <= 1'b0;
            rx_irq_en_reg <= 1'b0;
            order_reg <= 1'b0;
        end else if (wr_stat) begin
            tx_irq_en_reg <= pwdata[USF_TX_IRQ_EN_BIT];
            rx_irq_en_reg <= pwdata[USF_RX_IRQ_EN_BIT];
            order_reg <= pwdata[USF_ORDER_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seven_reg <= 1'b0;
        end else if (wr_ctrl) begin
            seven_reg <= pwdata[USF_SEVEN_BIT];
        end
    end

    // Order changes on any status write, even while a byte pends; a change voids a waiting byte
    assign order_change = wr_stat & (pwdata[USF_ORDER_BIT] != order_reg);
    assign bit_order_select = order_reg;
    assign seven_bit_mode = seven_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit buffer and holding-empty flag

    logic [7:0] tx_buf_reg;
    logic the_reg;
    logic the_next;
    logic tx_taken;

    // The engine only takes a byte while one is pending
    assign tx_taken = tx_shift_load & ~the_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_buf_reg <= USF_BYTE_RST;
        end else if (wr_data) begin
            // RULE14 seven-bit transmit
            tx_buf_reg <= seven_reg ? {1'b0, pwdata[6:0]} : pwdata[7:0];
        end
    end

    always_comb begin
        the_next = the_reg;
        if (wr_data) begin
            // RULE5 write clears empty
            the_next = 1'b0;
        end else if (tx_taken) begin
            // RULE6 load sets empty
            the_next = 1'b1;
        end else if (order_change && !the_reg) begin
            // RULE4 pending byte voided
            the_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            the_reg <= USF_THE_RST;
        end else begin
            the_reg <= the_next;
        end
    end

    assign tx_byte_valid = ~the_reg;

    // The buffer keeps software order; the stage reorders on the way out
    usf_order_if ord_if ();

    assign ord_if.byte_in = tx_buf_reg;
    assign ord_if.msb_first = order_reg;
    assign ord_if.seven_bit = seven_reg;

    usf_bit_order u_order (
        .ord(ord_if.stage)
    );

    // RULE3 ordered byte
    assign tx_shift_byte = ord_if.byte_out;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive buffer and flags

    logic [7:0] rx_buf_reg;
    logic rbf_reg;
    logic framing_err_reg;
    logic overrun_err_reg;
    logic parity_err_reg;
    logic err_clear;
    logic any_err;

    // Writing zero to the clear bit triggers the clear; writing one does nothing
    assign err_clear = wr_ctrl & ~pwdata[USF_EREC_BIT];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_buf_reg <= USF_BYTE_RST;
        end else if (rx_load) begin
            // RULE14 seven-bit receive
            rx_buf_reg <= seven_reg ? {1'b0, rx_char[6:0]} : rx_char;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rbf_reg <= 1'b0;
        end else if (rx_load) begin
            // RULE7 load sets full
            rbf_reg <= 1'b1;
        end else if (rd_data) begin
            // RULE8 read clears full
            rbf_reg <= 1'b0;
        end
    end

    // Each error flag: a new detect wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            framing_err_reg <= 1'b0;
        end else if (rx_load && rx_framing_err) begin
            // RULE9 framing set
            framing_err_reg <= 1'b1;
        end else if (err_clear) begin
            // RULE12 zero write clears
            framing_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overrun_err_reg <= 1'b0;
        end else if (rx_load && rbf_reg && !rd_data) begin
            // RULE10 overrun set
            overrun_err_reg <= 1'b1;
        end else if (err_clear) begin
            // RULE12 zero write clears
            overrun_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            parity_err_reg <= 1'b0;
        end else if (rx_load && rx_parity_err) begin
            // RULE11 parity set
            parity_err_reg <= 1'b1;
        end else if (err_clear) begin
            // RULE12 zero write clears
            parity_err_reg <= 1'b0;
        end
    end

    // Any error flag voids the buffer content until software clears it
    assign any_err = framing_err_reg | overrun_err_reg | parity_err_reg;
    // RULE13 invalid on error
    assign rx_data_valid = rbf_reg & ~any_err;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt requests

    // RULE1 transmit request
    // RULE16 level request
    assign tx_irq_req = tx_irq_en_reg & the_reg;
    // RULE2 receive request
    assign rx_irq_req = rx_irq_en_reg & (rbf_reg | any_err);

    // Interrupt pin: sticky event bits, separate from the enable-gated requests
    logic [USF_EV_W-1:0] ev;
    logic [USF_EV_W-1:0] istat_reg;
    logic [USF_EV_W-1:0] imask_reg;

    always_comb begin
        ev = '0;
        ev[USF_EV_TX] = tx_taken;
        ev[USF_EV_RX] = rx_load;
        ev[USF_EV_ERR] = rx_load & (rx_framing_err | rx_parity_err | (rbf_reg & ~rd_data));
    end

    // Sticky events; an event in the clearing cycle stays set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            istat_reg <= USF_EV_RST;
        end else if (wr_istat) begin
            istat_reg <= (istat_reg & ~pwdata[USF_EV_W-1:0]) | ev;
        end else begin
            istat_reg <= istat_reg | ev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            imask_reg <= USF_EV_RST;
        end else if (wr_imask) begin
            imask_reg <= pwdata[USF_EV_W-1:0];
        end
    end

    // The mask gates only the pin; status bits still record every event
    assign irq = |(istat_reg & imask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux

    // No side effect in the mux; the data read clears full in its own process
    always_comb begin
        prdata = 32'h0000_0000;
        if (usf_hit(paddr, USF_STAT_ADDR)) begin
            prdata[USF_TX_IRQ_EN_BIT] = tx_irq_en_reg;
            prdata[USF_RX_IRQ_EN_BIT] = rx_irq_en_reg;
            prdata[USF_ORDER_BIT] = order_reg;
            prdata[USF_THE_BIT] = the_reg;
            prdata[USF_RBF_BIT] = rbf_reg;
            prdata[USF_FRAMING_BIT] = framing_err_reg;
            prdata[USF_OVERRUN_BIT] = overrun_err_reg;
            prdata[USF_PARITY_BIT] = parity_err_reg;
        end else if (usf_hit(paddr, USF_DATA_ADDR)) begin
            // RULE15 read returns receive
            prdata[7:0] = rx_buf_reg;
        end else if (usf_hit(paddr, USF_CTRL_ADDR)) begin
            // Clear bit reads as one: it is a trigger, not stored
            prdata[USF_SEVEN_BIT] = seven_reg;
            prdata[USF_EREC_BIT] = 1'b1;
        end else if (usf_hit(paddr, USF_ISTAT_ADDR)) begin
            prdata[USF_EV_W-1:0] = istat_reg;
        end else if (usf_hit(paddr, USF_IMASK_ADDR)) begin
            prdata[USF_EV_W-1:0] = imask_reg;
        end
    end
endmodule : usf_top

// *** hw/usf_pkg.sv ***
// Package: register map, field positions and reset values of the serial status block
package usf_pkg;
    localparam int USF_AW = 5;
    // Register byte addresses
    localparam logic [USF_AW-1:0] USF_STAT_ADDR = 5'h00;
    localparam logic [USF_AW-1:0] USF_DATA_ADDR = 5'h04;
    localparam logic [USF_AW-1:0] USF_CTRL_ADDR = 5'h08;
    localparam logic [USF_AW-1:0] USF_ISTAT_ADDR = 5'h0C;
    localparam logic [USF_AW-1:0] USF_IMASK_ADDR = 5'h10;
    // Status register field positions
    localparam int USF_TX_IRQ_EN_BIT = 8;
    localparam int USF_RX_IRQ_EN_BIT = 9;
    localparam int USF_ORDER_BIT = 10;
    localparam int USF_THE_BIT = 11;
    localparam int USF_RBF_BIT = 12;
    localparam int USF_FRAMING_BIT = 13;
    localparam int USF_OVERRUN_BIT = 14;
    localparam int USF_PARITY_BIT = 15;
    // Control register field positions
    localparam int USF_SEVEN_BIT = 0;
    localparam int USF_EREC_BIT = 10;
    // Interrupt status and mask field positions
    localparam int USF_EV_TX = 0;
    localparam int USF_EV_RX = 1;
    localparam int USF_EV_ERR = 2;
    localparam int USF_EV_W = 3;
    // Reset values
    localparam logic [7:0] USF_BYTE_RST = 8'h00;
    localparam logic [USF_EV_W-1:0] USF_EV_RST = 3'h0;
    localparam logic USF_THE_RST = 1'b1;
endpackage : usf_pkg

// *** hw/usf_order_if.sv ***
// Interface: byte handed to the bit-order stage and the reordered result
interface usf_order_if;
    logic [7:0] byte_in;
    logic msb_first;
    logic seven_bit;
    logic [7:0] byte_out;
    modport ctrl (output byte_in, output msb_first, output seven_bit, input byte_out);
    modport stage (input byte_in, input msb_first, input seven_bit, output byte_out);
endinterface : usf_order_if

// *** hw/usf_bit_order.sv ***
// Bit-order stage: presents a byte so that the shift engine always sends bit 0 first
module usf_bit_order (
    // Order request and result
    usf_order_if.stage ord
);
    import usf_pkg::*;

    function automatic logic [7:0] usf_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : usf_rev8

    logic [7:0] rev;

    // RULE3 order select
    always_comb begin
        rev = usf_rev8(ord.byte_in);
        if (!ord.msb_first) begin
            ord.byte_out = ord.byte_in;
        end else if (ord.seven_bit) begin
            // Seven-bit characters reverse only the valid seven bits
            ord.byte_out = {1'b0, rev[7:1]};
        end else begin
            ord.byte_out = rev;
        end
    end
endmodule : usf_bit_order

// *** bench/usf_top_props.sv ***
// Checker: port-level properties of the serial status block
module usf_top_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usf_pkg::USF_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Engines, modes and requests
    input wire logic tx_shift_load,
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_shift_byte,
    input wire logic rx_load,
    input wire logic [7:0] rx_char,
    input wire logic rx_framing_err,
    input wire logic rx_parity_err,
    input wire logic rx_data_valid,
    input wire logic bit_order_select,
    input wire logic seven_bit_mode,
    input wire logic tx_irq_req,
    input wire logic rx_irq_req,
    input wire logic irq
);
    import usf_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire acc = psel && penable && pready;
    wire wr_dat = acc && pwrite && paddr == USF_DATA_ADDR;
    wire rd_dat = acc && !pwrite && paddr == USF_DATA_ADDR;
    wire wr_st = acc && pwrite && paddr == USF_STAT_ADDR;
    wire wr_ctl = acc && pwrite && paddr == USF_CTRL_ADDR;
    wire mapped = paddr inside {USF_STAT_ADDR, USF_DATA_ADDR, USF_CTRL_ADDR, USF_ISTAT_ADDR,
        USF_IMASK_ADDR};
    function automatic logic [7:0] rev8(input logic [7:0] b);
        return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
    endfunction : rev8
    ////////////////////////////////////////////////////////////////
    tx_fill_a:
        assert property (wr_dat |=> tx_byte_valid) else $error("tx byte not pending");
    tx_take_a:
        assert property (tx_shift_load && tx_byte_valid && !wr_dat |=> !tx_byte_valid)
            else $error("tx empty not set");
    tx_irq_a:
        assert property (tx_irq_req |-> !tx_byte_valid) else $error("tx irq while pending");
    irq_hold_a:
        assert property (tx_irq_req && !wr_dat && !wr_st |=> tx_irq_req)
            else $error("tx irq dropped");
    order_void_a:
        assert property (wr_st && pwdata[USF_ORDER_BIT] != bit_order_select && tx_byte_valid
            && !tx_shift_load |=> !tx_byte_valid) else $error("stale byte kept");
    rx_err_a:
        assert property (rx_load && (rx_framing_err || rx_parity_err) |=> !rx_data_valid)
            else $error("bad char valid");
    rx_ovr_a:
        assert property (rx_load && rx_data_valid && !rd_dat |=> !rx_data_valid)
            else $error("overrun char valid");
    rx_read_a:
        assert property (rd_dat && !rx_load |=> !rx_data_valid) else $error("full not cleared");
    rx_irq_a:
        assert property ($rose(rx_irq_req) |-> $past(rx_load) || $past(wr_st))
            else $error("rx irq without cause");
    msb_order_a:
        assert property (wr_dat && bit_order_select && !seven_bit_mode
            |=> tx_shift_byte == rev8($past(pwdata[7:0]))) else $error("msb order wrong");
    lsb_seven_a:
        assert property (wr_dat && !bit_order_select && seven_bit_mode
            |=> tx_shift_byte == {1'b0, $past(pwdata[6:0])}) else $error("seven bit wrong");
    slverr_map_a:
        assert property (pslverr == (acc && !mapped)) else $error("slave error wrong");
    order_pin_a:
        assert property (wr_st |=> bit_order_select == $past(pwdata[USF_ORDER_BIT]))
            else $error("order bit not stored");
    mode_pin_a:
        assert property (wr_ctl |=> seven_bit_mode == $past(pwdata[USF_SEVEN_BIT]))
            else $error("mode bit not stored");
    cover property (tx_shift_load && tx_byte_valid);
    cover property (rx_load && rx_data_valid);
    cover property (rx_load && rx_framing_err);
endmodule : usf_top_props

bind usf_top usf_top_props chk (.*);

// *** bench/usf_engine_model.sv ***
// Engine model: shift engine and receiver as seen from the status block
module usf_engine_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Transmit side
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_shift_byte,
    input wire logic [3:0] stall,
    output logic tx_shift_load,
    output logic [7:0] sent,
    // Receive commands and lines
    input wire logic rx_go,
    input wire logic [7:0] rx_val,
    input wire logic ferr,
    input wire logic perr,
    output logic rx_load,
    output logic [7:0] rx_char,
    output logic rx_framing_err,
    output logic rx_parity_err
);
    logic [3:0] wait_reg;
    // Takes a pending byte after a programmable stall
    always_ff @(posedge clk_sys) begin
        if (rst || !tx_byte_valid || tx_shift_load) begin
            wait_reg <= 4'h0;
            tx_shift_load <= 1'b0;
        end else if (wait_reg == stall) tx_shift_load <= 1'b1;
        else wait_reg <= wait_reg + 4'h1;
        if (tx_shift_load) sent <= tx_shift_byte;
    end
    // Idle lines toggle so nothing stale can pass for a character
    always_ff @(posedge clk_sys) begin
        rx_load <= !rst && rx_go;
        rx_char <= rst ? 8'h00 : rx_go ? rx_val : ~rx_char;
        rx_framing_err <= rst ? 1'b0 : rx_go ? ferr : ~rx_framing_err;
        rx_parity_err <= rst ? 1'b0 : rx_go ? perr : ~rx_parity_err;
    end
endmodule : usf_engine_model

// *** bench/usf_top_test.sv ***
// Testbench: APB traffic and engine stimulus for the serial status block
module usf_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import usf_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [USF_AW-1:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h5D002153, d;
    logic pready, pslverr, tx_shift_load, tx_byte_valid, rx_load, rx_framing_err;
    logic rx_parity_err, rx_data_valid, bit_order_select, seven_bit_mode;
    logic tx_irq_req, rx_irq_req, irq, rx_go = 1'b0, ferr = 1'b0, perr = 1'b0;
    logic [7:0] tx_shift_byte, rx_char, sent, e8, rx_val = 8'h00;
    logic [3:0] stall = 4'h0;
    logic [31:0] eq[$], mq[$];
    int err_count = 0, n_tests = 0, i, k;
    localparam logic [31:0] SM = 32'h0000FF00;
    initial forever #5 clk_sys = ~clk_sys;
    usf_top uut (.*);
    usf_engine_model eng (.clk_sys, .rst, .tx_byte_valid, .tx_shift_byte, .stall,
        .tx_shift_load, .sent, .rx_go, .rx_val, .ferr, .perr, .rx_load, .rx_char,
        .rx_framing_err, .rx_parity_err);
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_flag(input logic g, input logic e);
        chk(32'(g), 32'(e));
    endtask : chk_flag
    // Reads queue their expectation; the monitor checks at the access edge
    task automatic apb(input logic w, input logic [USF_AW-1:0] a, input logic [31:0] wd,
        input logic [31:0] e = 32'h0, input logic [31:0] m = 32'h0);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        if (!w) begin
            eq.push_back(e);
            mq.push_back(m);
        end
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_sys);
    endtask : apb
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite && eq.size() != 0) begin
            chk(prdata & mq[0], eq[0] & mq[0]);
            void'(eq.pop_front());
            void'(mq.pop_front());
        end
    end
    task automatic rx(input logic [7:0] v, input logic f, input logic p);
        @(posedge clk_sys);
        rx_go <= 1'b1;
        rx_val <= v;
        ferr <= f;
        perr <= p;
        @(posedge clk_sys);
        rx_go <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : rx
    task automatic print_verdict();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        #100us;
        err_count++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h00000800, SM);
        apb(1'b0, 5'h14, 32'h0, 32'h0, 32'hFFFFFFFF);
        apb(1'b1, USF_IMASK_ADDR, 32'h00000007);
        apb(1'b1, USF_STAT_ADDR, 32'h00000300);
        chk_flag(tx_irq_req, 1'b1);
        // Pass 0 lsb first, 1 msb first, 2 seven-bit lsb first
        for (i = 0; i < 3; i++) begin
            d = (i == 2) ? 32'h00000401 : 32'h00000400;
            apb(1'b1, USF_CTRL_ADDR, d);
            apb(1'b0, USF_CTRL_ADDR, 32'h0, d, 32'h00000401);
            // order set only while nothing pends
            apb(1'b1, USF_STAT_ADDR, (i == 1) ? 32'h00000700 : 32'h00000300);
            d = rnd();
            stall <= 4'(i * 3);
            e8 = (i == 1) ? {<<{d[7:0]}} : (i == 2) ? {1'b0, d[6:0]} : d[7:0];
            apb(1'b1, USF_DATA_ADDR, d);
            chk_flag(tx_byte_valid, 1'b1);
            chk_flag(tx_irq_req, 1'b0);
            k = 0;
            while (tx_shift_load !== 1'b1 && k < 50) begin
                @(negedge clk_sys);
                k++;
            end
            chk_flag(tx_shift_load, 1'b1);
            @(negedge clk_sys);
            chk(32'(sent), 32'(e8));
            chk_flag(tx_byte_valid, 1'b0);
            chk_flag(tx_irq_req & irq, 1'b1);
            apb(1'b1, USF_ISTAT_ADDR, 32'h00000007);
            chk_flag(irq, 1'b0);
        end
        apb(1'b1, USF_CTRL_ADDR, 32'h00000400);
        // Order flipped while a byte waits: the byte is dropped
        stall <= 4'hF;
        apb(1'b1, USF_DATA_ADDR, rnd());
        apb(1'b1, USF_STAT_ADDR, 32'h00000700);
        chk_flag(tx_byte_valid, 1'b0);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h00000F00, SM);
        d = rnd();
        rx(d[7:0], 1'b0, 1'b0);
        chk(32'({rx_data_valid, rx_irq_req, irq}), 32'h7);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h00001F00, SM);
        apb(1'b0, USF_DATA_ADDR, 32'h0, d, 32'h000000FF);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h00000F00, SM);
        chk(32'({rx_data_valid, rx_irq_req}), 32'h0);
        apb(1'b1, USF_ISTAT_ADDR, 32'h00000002);
        chk_flag(irq, 1'b0);
        rx(8'(rnd()), 1'b0, 1'b0);
        d = rnd();
        rx(d[7:0], 1'b0, 1'b0);
        chk_flag(rx_data_valid, 1'b0);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h00005F00, SM);
        rx(d[7:0], 1'b1, 1'b1);
        chk_flag(rx_irq_req, 1'b1);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h0000FF00, SM);
        apb(1'b1, USF_CTRL_ADDR, 32'h00000400);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h0000FF00, SM);
        apb(1'b1, USF_CTRL_ADDR, 32'h00000000);
        apb(1'b0, USF_STAT_ADDR, 32'h0, 32'h00001F00, SM);
        chk_flag(rx_data_valid, 1'b1);
        apb(1'b0, USF_DATA_ADDR, 32'h0, d, 32'h000000FF);
        // Seven-bit receive drops the top bit of the character
        apb(1'b1, USF_CTRL_ADDR, 32'h00000401);
        d = rnd() | 32'h00000080;
        rx(d[7:0], 1'b0, 1'b0);
        apb(1'b0, USF_DATA_ADDR, 32'h0, {25'h0, d[6:0]}, 32'h000000FF);
        print_verdict();
    end
endmodule : usf_top_test
